// ### rtl/cid_out_defines.svh
// register offsets, field positions, reset values and timing counts of the caller id output
`ifndef CID_OUT_DEFINES_SVH
`define CID_OUT_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CID_REG_CTRL    4'h0
`define CID_REG_STATUS  4'h4
`define CID_REG_MASK    4'h8
`define CID_REG_DATA    4'hc
`define CID_ADDR_W      4

// ****************************************
// fields
// ****************************************
`define CID_CTRL_FSK_EN 0
`define CID_CTRL_RESET  1'h1
`define CID_EV_RING     0
`define CID_EV_BYTE     1
`define CID_EV_ALERT    2
`define CID_EV_W        3
`define CID_RESP_OKAY   2'h0
`define CID_RESP_SLVERR 2'h2

// ****************************************
// synchronised pin indices
// ****************************************
`define CID_PIN_RING    0
`define CID_PIN_RC      1
`define CID_PIN_SCLK    2
`define CID_PIN_FSK     3
`define CID_PIN_ALERT   4
`define CID_PIN_MODE    5
`define CID_PIN_IRQ     6
`define CID_PINS        7
// reset image of the synchronisers: ring quiet, rc charged, fsk mark, sclk low,
// mode 1, irq wire released; a busy reset image would fake ring and alert edges
`define CID_PIN_IDLE    7'h6a

// ****************************************
// timing
// ****************************************
`define CID_CLK_HZ      25000000
`define CID_BAUD_HZ     1200
`define CID_BIT_CYCLES  (`CID_CLK_HZ / `CID_BAUD_HZ)

`endif

// ### rtl/cid_out_pkg.sv
// types shared by the caller id output modules
package cid_out_pkg;
  typedef enum logic [1:0] {
    CID_RX_IDLE  = 2'h0,
    CID_RX_START = 2'h1,
    CID_RX_DATA  = 2'h3,
    CID_RX_STOP  = 2'h2
  } cid_rx_state_e;
endpackage

// ### rtl/cid_rx_if.sv
// carrier between the byte assembler and the output logic
interface cid_rx_if;
  logic       bit_lvl;
  logic       enable;
  logic       tick;
  logic       phase_hi;
  logic       byte_done;
  logic [7:0] byte_val;
  modport asm (input bit_lvl, enable, output tick, phase_hi, byte_done, byte_val);
  modport top (output bit_lvl, enable, input tick, phase_hi, byte_done, byte_val);
endinterface

// ### rtl/cid_byte_asm.sv
// bit timing recovery and character assembly of the demodulated fsk stream
`include "cid_out_defines.svh"
module cid_byte_asm
  import cid_out_pkg::*;
#(
  parameter int BIT_CYCLES = `CID_BIT_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  cid_rx_if.asm     rx
);
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF     = 16'(BIT_CYCLES / 2);

  typedef struct packed {
    cid_rx_state_e st;
    logic [15:0]   cnt;
    logic [7:0]    bits;
    logic [2:0]    idx;
    logic          prev;
    logic          tick;
    logic          phase;
    logic          done;
    logic [7:0]    byte_q;
  } cid_asm_s;

  cid_asm_s r_reg;
  cid_asm_s r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    r_next.done = 1'b0;
    r_next.prev = rx.bit_lvl;
    // free running bit clock, realigned on every start edge
    if (r_reg.cnt == BIT_LAST) begin
      r_next.cnt  = 16'h0000;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + 16'h0001;
    end
    unique case (r_reg.st)
      CID_RX_IDLE: begin
        if (rx.enable && r_reg.prev && !rx.bit_lvl) begin
          r_next.st  = CID_RX_START;
          r_next.cnt = 16'h0000;
        end
      end
      CID_RX_START: begin
        // a start bit that is gone at mid-bit was a glitch
        if (r_reg.cnt == HALF - 16'h0001) begin
          r_next.st  = rx.bit_lvl ? CID_RX_IDLE : CID_RX_DATA;
          r_next.idx = 3'h0;
        end
      end
      CID_RX_DATA: begin
        if (r_reg.cnt == HALF - 16'h0001) begin
          r_next.bits = {rx.bit_lvl, r_reg.bits[7:1]};
          r_next.idx  = r_reg.idx + 3'h1;
          if (r_reg.idx == 3'h7) begin
            r_next.st = CID_RX_STOP;
          end
        end
      end
      CID_RX_STOP: begin
        // start and stop are stripped; a missing stop bit drops the character
        if (r_reg.cnt == HALF - 16'h0001) begin
          r_next.st     = CID_RX_IDLE;
          r_next.done   = rx.bit_lvl;
          r_next.byte_q = rx.bit_lvl ? r_reg.bits : r_reg.byte_q;
        end
      end
    endcase
    if (!rx.enable) begin
      r_next.st = CID_RX_IDLE;
    end
    r_next.phase = (r_next.cnt < HALF);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_reg <= '{st: CID_RX_IDLE, prev: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign rx.tick      = r_reg.tick;
  assign rx.phase_hi  = r_reg.phase;
  assign rx.byte_done = r_reg.done;
  assign rx.byte_val  = r_reg.byte_q;
endmodule

// ### rtl/cid_out_top.sv
// caller id serial output, ring indication and interrupt logic with axi4-lite registers
//
// Summary of operation
// - mode 0 drives clock and data itself
// - mode 1 host clocks out each byte
// - mode 1 flags complete byte ready
// - mode pin low mode 0, high 1
// - recover data at 1200 baud
// - ring detect low on ring activity
// - ring detect held until rc releases
// - mode 1 shift on host rising edge
// - mode 0 ready marks byte boundary
// - mark is one, space is zero
// - interrupt low while any source active
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`include "cid_out_defines.svh"
module cid_out_top
  import cid_out_pkg::*;
#(
  parameter int BIT_CYCLES = `CID_BIT_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // ****************************************
  // axi4-lite slave
  // ****************************************
  input  wire logic [3:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [3:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic             irq_out,
  // ****************************************
  // device pins
  // ****************************************
  input  wire logic        mode_sel_in,
  input  wire logic        fsk_bit_in,
  input  wire logic        alert_tone_valid_in,
  input  wire logic        ring_sense_in,
  input  wire logic        ring_hold_rc_in,
  output logic             ring_hold_rc_out,
  output logic             ring_hold_rc_oe_out,
  output logic             ring_detect_n_out,
  input  wire logic        serial_shift_clock_in,
  output logic             serial_shift_clock_out,
  output logic             serial_shift_clock_oe_out,
  output logic             serial_data_out,
  output logic             byte_ready_n_out,
  input  wire logic        irq_n_in,
  output logic             irq_n_out,
  output logic             irq_n_oe_out
);

  typedef struct packed {
    logic [`CID_PINS-1:0] s1;
    logic [`CID_PINS-1:0] s2;
    logic                 sclk_prev;
    logic                 alert_prev;
    logic                 ring_n;
    logic                 rc_oe;
    logic                 sclk_q;
    logic                 sclk_oe;
    logic                 data_q;
    logic                 rdy_n;
    logic [7:0]           shift;
    logic [3:0]           nbit;
    logic                 irq_pin_oe;
    logic                 ctrl_en;
    logic [`CID_EV_W-1:0] status;
    logic [`CID_EV_W-1:0] mask;
    logic [7:0]           last_byte;
    logic                 irq;
    logic [3:0]           awaddr;
    logic                 aw_have;
    logic [31:0]          wdata;
    logic                 wstrb0;
    logic                 w_have;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } cid_top_s;

  cid_top_s r_reg;
  cid_top_s r_next;

  cid_rx_if rx ();

  cid_byte_asm #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_asm (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .rx      (rx)
  );

  assign rx.bit_lvl = r_reg.s2[`CID_PIN_FSK];
  assign rx.enable  = r_reg.ctrl_en;

  function automatic logic addr_known(input logic [3:0] a);
    addr_known = (a == `CID_REG_CTRL) || (a == `CID_REG_STATUS) ||
                 (a == `CID_REG_MASK) || (a == `CID_REG_DATA);
  endfunction

  logic                 mode1;
  logic                 ring_act;
  logic                 sclk_rise;
  logic                 wr_fire;
  logic [`CID_EV_W-1:0] ev_set;
  logic [`CID_EV_W-1:0] ev_clr;

  always_comb begin
    r_next            = r_reg;
    r_next.s1         = {irq_n_in, mode_sel_in, alert_tone_valid_in, fsk_bit_in,
                         serial_shift_clock_in, ring_hold_rc_in, ring_sense_in};
    r_next.s2         = r_reg.s1;
    r_next.sclk_prev  = r_reg.s2[`CID_PIN_SCLK];
    r_next.alert_prev = r_reg.s2[`CID_PIN_ALERT];
    mode1             = r_reg.s2[`CID_PIN_MODE];
    ring_act          = r_reg.s2[`CID_PIN_RING];
    sclk_rise         = r_reg.s2[`CID_PIN_SCLK] && !r_reg.sclk_prev;
    ev_set            = '0;
    ev_clr            = '0;

    // ****************************************
    // ring indication
    // ****************************************
    // the rc pin is held discharged while ringing; after release the
    // indication waits for the capacitor to charge past the threshold
    r_next.rc_oe = ring_act;
    if (ring_act) begin
      r_next.ring_n = 1'b0;
    end else if (r_reg.s2[`CID_PIN_RC] && !r_reg.rc_oe) begin
      r_next.ring_n = 1'b1;
    end
    ev_set[`CID_EV_RING]  = r_reg.ring_n && !r_next.ring_n;
    ev_set[`CID_EV_ALERT] = r_reg.s2[`CID_PIN_ALERT] && !r_reg.alert_prev;
    ev_set[`CID_EV_BYTE]  = rx.byte_done;
    if (rx.byte_done) begin
      r_next.last_byte = rx.byte_val;
    end

    // ****************************************
    // serial output
    // ****************************************
    if (!mode1) begin
      // device paced stream: clock follows recovered bit timing
      r_next.sclk_oe = 1'b1;
      r_next.sclk_q  = rx.phase_hi;
      r_next.data_q  = r_reg.s2[`CID_PIN_FSK];
      r_next.nbit    = 4'h8;
      if (rx.byte_done) begin
        r_next.rdy_n = 1'b0;
      end else if (rx.tick) begin
        r_next.rdy_n = 1'b1;
      end
    end else begin
      r_next.sclk_oe = 1'b0;
      r_next.sclk_q  = 1'b0;
      // a new byte overwrites one that is not fully read yet
      if (rx.byte_done) begin
        r_next.shift = rx.byte_val;
        r_next.data_q = rx.byte_val[0];
        r_next.nbit  = 4'h0;
        r_next.rdy_n = 1'b0;
      end else if (sclk_rise && r_reg.nbit != 4'h8) begin
        r_next.shift  = {1'b0, r_reg.shift[7:1]};
        r_next.data_q = r_reg.shift[1];
        r_next.nbit   = r_reg.nbit + 4'h1;
        if (r_reg.nbit == 4'h7) begin
          r_next.rdy_n = 1'b1;
        end
      end
    end
    r_next.irq_pin_oe = !r_next.ring_n || !r_next.rdy_n ||
                        r_reg.s2[`CID_PIN_ALERT];

    // ****************************************
    // axi4-lite write
    // ****************************************
    if (s_axi_awvalid_in && r_reg.awready) begin
      r_next.awaddr  = s_axi_awaddr_in;
      r_next.aw_have = 1'b1;
    end
    if (s_axi_wvalid_in && r_reg.wready) begin
      r_next.wdata  = s_axi_wdata_in;
      r_next.wstrb0 = s_axi_wstrb_in[0];
      r_next.w_have = 1'b1;
    end
    wr_fire = r_reg.aw_have && r_reg.w_have && !r_reg.bvalid;
    if (wr_fire) begin
      r_next.aw_have = 1'b0;
      r_next.w_have  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = addr_known(r_reg.awaddr) ? `CID_RESP_OKAY : `CID_RESP_SLVERR;
      if (r_reg.wstrb0) begin
        unique case (r_reg.awaddr)
          `CID_REG_CTRL:   r_next.ctrl_en = r_reg.wdata[`CID_CTRL_FSK_EN];
          `CID_REG_STATUS: ev_clr = r_reg.wdata[`CID_EV_W-1:0];
          `CID_REG_MASK:   r_next.mask = r_reg.wdata[`CID_EV_W-1:0];
          default: ;
        endcase
      end
    end else if (r_reg.bvalid && s_axi_bready_in) begin
      r_next.bvalid = 1'b0;
    end
    // an event in the clearing cycle survives
    r_next.status  = (r_reg.status & ~ev_clr) | ev_set;
    r_next.irq     = |(r_next.status & r_next.mask);
    r_next.awready = !r_next.aw_have && !r_next.bvalid;
    r_next.wready  = !r_next.w_have && !r_next.bvalid;

    // ****************************************
    // axi4-lite read
    // ****************************************
    if (s_axi_arvalid_in && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = addr_known(s_axi_araddr_in) ? `CID_RESP_OKAY : `CID_RESP_SLVERR;
      unique case (s_axi_araddr_in)
        `CID_REG_CTRL:   r_next.rdata = {31'h0, r_reg.ctrl_en};
        `CID_REG_STATUS: r_next.rdata = {29'h0, r_reg.status};
        `CID_REG_MASK:   r_next.rdata = {29'h0, r_reg.mask};
        `CID_REG_DATA:   r_next.rdata = {20'h0, r_reg.s2[`CID_PIN_IRQ], r_reg.rdy_n,
                                         r_reg.ring_n, mode1, r_reg.last_byte};
        default:         r_next.rdata = 32'h0;
      endcase
    end else if (r_reg.rvalid && s_axi_rready_in) begin
      r_next.rvalid = 1'b0;
    end
    r_next.arready = !r_next.rvalid;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r_reg <= '{s1: `CID_PIN_IDLE, s2: `CID_PIN_IDLE, ring_n: 1'b1, rdy_n: 1'b1,
                 nbit: 4'h8, data_q: 1'b1, ctrl_en: `CID_CTRL_RESET, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign s_axi_awready_out         = r_reg.awready;
  assign s_axi_wready_out          = r_reg.wready;
  assign s_axi_bvalid_out          = r_reg.bvalid;
  assign s_axi_bresp_out           = r_reg.bresp;
  assign s_axi_arready_out         = r_reg.arready;
  assign s_axi_rvalid_out          = r_reg.rvalid;
  assign s_axi_rdata_out           = r_reg.rdata;
  assign s_axi_rresp_out           = r_reg.rresp;
  assign irq_out                   = r_reg.irq;
  assign ring_hold_rc_out          = 1'b0;
  assign ring_hold_rc_oe_out       = r_reg.rc_oe;
  assign ring_detect_n_out         = r_reg.ring_n;
  assign serial_shift_clock_out    = r_reg.sclk_q;
  assign serial_shift_clock_oe_out = r_reg.sclk_oe;
  assign serial_data_out           = r_reg.data_q;
  assign byte_ready_n_out          = r_reg.rdy_n;
  assign irq_n_out                 = 1'b0;
  assign irq_n_oe_out              = r_reg.irq_pin_oe;
endmodule

// ### test/cid_out_sva.sv
// concurrent checks on the caller id output top ports
module cid_out_sva (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        mode_sel_in,
  input wire logic        fsk_bit_in,
  input wire logic        alert_tone_valid_in,
  input wire logic        ring_sense_in,
  input wire logic        ring_hold_rc_in,
  input wire logic        serial_shift_clock_in,
  input wire logic        ring_hold_rc_oe_out,
  input wire logic        ring_detect_n_out,
  input wire logic        serial_shift_clock_oe_out,
  input wire logic        serial_data_out,
  input wire logic        byte_ready_n_out,
  input wire logic        irq_n_oe_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // ****
  // pins and axi4-lite response holds
  // ****
  a_ring_shown: assert property (ring_sense_in[*5] |-> !ring_detect_n_out && ring_hold_rc_oe_out)
    else $error("ring activity not indicated");
  a_ring_held: assert property (!ring_hold_rc_in[*4] |-> !$rose(ring_detect_n_out))
    else $error("ring indication released while rc low");
  a_irq_source: assert property ((!ring_detect_n_out || !byte_ready_n_out)[*2] |-> irq_n_oe_out)
    else $error("irq wire not pulled");
  a_irq_release: assert property (!alert_tone_valid_in[*4] ##1
    (!alert_tone_valid_in && ring_detect_n_out && byte_ready_n_out)[*2] |-> !irq_n_oe_out)
    else $error("irq wire not released");
  a_mode0_clock: assert property (!mode_sel_in[*5] |-> serial_shift_clock_oe_out)
    else $error("mode 0 clock not driven");
  a_mode1_clock: assert property (mode_sel_in[*5] |-> !serial_shift_clock_oe_out)
    else $error("mode 1 clock driven");
  a_data_level: assert property ((!mode_sel_in && $stable(fsk_bit_in))[*6]
    |-> serial_data_out == fsk_bit_in)
    else $error("mode 0 data differs from bit level");
  a_shift_idle: assert property ((mode_sel_in && !serial_shift_clock_in)[*6]
    |-> $stable(serial_data_out) || $fell(byte_ready_n_out))
    else $error("data moved without host clock rise");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
endmodule

// ### test/cid_host_model.sv
// host side model: clocks each byte out of the device in mode 1
module cid_host_model (
  input  wire logic       read_req_in,
  input  wire logic       clk_in,
  input  wire logic       data_in,
  output logic            sclk_out,
  output logic [7:0]      byte_out,
  output logic            done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // clock rests low between reads; 320 ns period, every edge 7 ns after a clk_in rise
  initial begin
    sclk_out = 1'b0;
    byte_out = 8'h00;
    done_out = 1'b0;
    forever begin
      @(posedge clk_in iff read_req_in);
      #7;
      for (int i = 0; i < 8; i++) begin
        #160;
        byte_out[i] = data_in;
        sclk_out = 1'b1;
        #160;
        sclk_out = 1'b0;
      end
      done_out = 1'b1;
      wait (!read_req_in);
      done_out = 1'b0;
    end
  end
endmodule

// ### test/test_caller_id_output_interface.sv
// self-checking bench of the caller id output top
`include "cid_out_defines.svh"
module test_caller_id_output_interface;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BC = 16;
  localparam int RC_CYC = 40;
  logic clk_in = 1'b0, rstn_in = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, mode = 1'b1, fsk = 1'b1, alert = 1'b0;
  logic ring = 1'b0, rd_req = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'hb0c8, d;
  logic [1:0] bresp, rresp, r;
  logic rc_o, rc_oe, rdet_n, sclk_o, sclk_oe, data_o, rdy_n, irq_o, irq_oe, h_sclk, h_done;
  logic [7:0] h_byte, rc_cnt = 8'h00, b;
  int mismatches = 0, total_checks = 0;
  wire sclk_pin = sclk_oe ? sclk_o : h_sclk;
  wire irq_wire = irq_oe ? irq_o : 1'b1;
  wire rc_pin = rc_oe ? rc_o : (rc_cnt == RC_CYC);
  always #20 clk_in = ~clk_in;
  // rc node charges through its pull-up once released
  always @(posedge clk_in) rc_cnt <= rc_oe ? 8'h00 : rc_cnt + 8'(rc_cnt < RC_CYC);
  cid_out_top #(.BIT_CYCLES(BC)) i_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .irq_out(irq),
    .mode_sel_in(mode), .fsk_bit_in(fsk), .alert_tone_valid_in(alert),
    .ring_sense_in(ring), .ring_hold_rc_in(rc_pin), .ring_hold_rc_out(rc_o),
    .ring_hold_rc_oe_out(rc_oe), .ring_detect_n_out(rdet_n),
    .serial_shift_clock_in(sclk_pin), .serial_shift_clock_out(sclk_o),
    .serial_shift_clock_oe_out(sclk_oe), .serial_data_out(data_o),
    .byte_ready_n_out(rdy_n), .irq_n_in(irq_wire), .irq_n_out(irq_o), .irq_n_oe_out(irq_oe));
  cid_host_model i_host (.read_req_in(rd_req), .clk_in(clk_in), .data_in(data_o),
    .sclk_out(h_sclk), .byte_out(h_byte), .done_out(h_done));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] st(input logic rg, input logic by, input logic al);
    return {29'h0, al, by, rg};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 3000) begin
      mismatches++;
      $display("[ERR] %0t wait ran out", $time);
      stop_test();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wait_lvl(ref logic s, input logic lvl);
    int n = 0;
    while (s !== lvl && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    hang(n);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge clk_in);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    do begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 3000);
    r = bresp;
    bready <= 1'b0;
    hang(n);
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int n = 0;
    @(posedge clk_in);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 3000);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
    hang(n);
  endtask
  task automatic send_byte(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      fsk <= f[i];
      cyc(BC);
    end
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    cyc(4);
    rstn_in <= 1'b1;
    axi_rd(`CID_REG_CTRL);
    chk(d, 32'h1);
    chk(r, `CID_RESP_OKAY);
    chk(rdet_n, 1'b1);
    chk(irq_oe, 1'b0);
    axi_rd(`CID_REG_MASK);
    chk(d, 32'h0);
    axi_wr(`CID_REG_MASK, 32'h7);
    chk(r, `CID_RESP_OKAY);
    axi_wr(4'h2, 32'h0);
    chk(r, `CID_RESP_SLVERR);
    for (int k = 0; k < 5; k++) begin
      b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : xs() >> 8;
      send_byte(b);
      wait_lvl(rdy_n, 1'b0);
      cyc(2);
      chk(irq, 1'b1);
      chk(irq_wire, 1'b0);
      axi_rd(`CID_REG_DATA);
      chk(d[7:0], b);
      chk(d[11:8], 4'h3);
      rd_req <= 1'b1;
      wait_lvl(h_done, 1'b1);
      rd_req <= 1'b0;
      chk(h_byte, b);
      cyc(4);
      chk(rdy_n, 1'b1);
      axi_wr(`CID_REG_STATUS, st(0, 1, 0));
      axi_rd(`CID_REG_STATUS);
      chk(d, 32'h0);
      chk(irq, 1'b0);
    end
    axi_wr(`CID_REG_CTRL, 32'h0);
    send_byte(8'h5a);
    cyc(4);
    chk(rdy_n, 1'b1);
    axi_rd(`CID_REG_STATUS);
    chk(d, 32'h0);
    axi_wr(`CID_REG_CTRL, 32'h1);
    axi_rd(`CID_REG_CTRL);
    chk(d, 32'h1);
    mode <= 1'b0;
    cyc(6);
    chk(sclk_oe, 1'b1);
    b = 8'(xs() >> 3);
    send_byte(b);
    wait_lvl(rdy_n, 1'b0);
    wait_lvl(rdy_n, 1'b1);
    axi_rd(`CID_REG_DATA);
    chk(d[8:0], {1'b0, b});
    axi_wr(`CID_REG_STATUS, 32'h7);
    ring <= 1'b1;
    cyc(8);
    chk(rdet_n, 1'b0);
    chk(irq_wire, 1'b0);
    ring <= 1'b0;
    cyc(RC_CYC / 2);
    chk(rdet_n, 1'b0);
    wait_lvl(rdet_n, 1'b1);
    axi_rd(`CID_REG_STATUS);
    chk(d, st(1, 0, 0));
    axi_wr(`CID_REG_MASK, 32'h0);
    axi_wr(`CID_REG_STATUS, 32'h7);
    alert <= 1'b1;
    cyc(6);
    chk(irq_wire, 1'b0);
    chk(irq, 1'b0);
    axi_rd(`CID_REG_STATUS);
    chk(d, st(0, 0, 1));
    alert <= 1'b0;
    cyc(6);
    chk(irq_wire, 1'b1);
    stop_test();
  end
endmodule
bind cid_out_top cid_out_sva i_sva (.clk_in(clk_in), .rstn_in(rstn_in),
  .mode_sel_in(mode_sel_in), .fsk_bit_in(fsk_bit_in), .alert_tone_valid_in(alert_tone_valid_in),
  .ring_sense_in(ring_sense_in), .ring_hold_rc_in(ring_hold_rc_in),
  .serial_shift_clock_in(serial_shift_clock_in), .ring_hold_rc_oe_out(ring_hold_rc_oe_out),
  .ring_detect_n_out(ring_detect_n_out), .serial_shift_clock_oe_out(serial_shift_clock_oe_out),
  .serial_data_out(serial_data_out), .byte_ready_n_out(byte_ready_n_out),
  .irq_n_oe_out(irq_n_oe_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .s_axi_rdata_out(s_axi_rdata_out));
